//--- test/mfr_host_model.sv
// Host model: issues register strobes as the serial front end would.
// Assumes clk from the bench; requests change on the falling edge.
`timescale 1ns/100ps
`default_nettype none
module mfr_host_model (
   input  wire logic       clk,           // Clock
   input  wire logic [7:0] reg_rdata_ff,  // Read data
   input  wire logic       reg_rvalid_ff, // Answer pulse
   output var  logic       reg_wr,        // Write strobe
   output var  logic       reg_rd,        // Read strobe
   output var  logic [6:0] reg_addr,      // Offset
   output var  logic [7:0] reg_wdata      // Write data
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 7'h7f;
      reg_wdata = 8'h00;
   end
   // Idle bus shows inverted values so stale data never matches
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   // One strobe, then at most three cycles for the answer
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      d = 8'hxx;
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      for (int n = 0; n < 3 && reg_rvalid_ff !== 1'b1; n++)
         @(negedge clk);
      if (reg_rvalid_ff === 1'b1)
         d = reg_rdata_ff;
   endtask
endmodule
`default_nettype wire

//--- test/mfr_regs_checker.sv
// Timing checks on the register bank ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module mfr_regs_checker (
   input wire logic       clk,                      // Clock
   input wire logic       reset,                    // Reset
   input wire logic       reg_wr,                   // Write strobe
   input wire logic       reg_rd,                   // Read strobe
   input wire logic [6:0] reg_addr,                 // Offset
   input wire logic [7:0] reg_wdata,                // Write data
   input wire logic       reg_rvalid_ff,            // Answer pulse
   input wire logic [7:0] irq_event,                // Events
   input wire logic [2:0] rx_amp_gain_code_ff,      // Gain
   input wire logic [1:0] high_band_amp_current_ff, // High band
   input wire logic       high_band_boost_ff,       // Boost
   input wire logic [7:0] tx_buffer_base_ff,        // Tx base
   input wire logic [7:0] rx_buffer_base_ff,        // Rx base
   input wire logic       irq_ff                    // Interrupt
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   logic [7:0] wd_q;
   logic [7:0] wd_q2;
   wire        amp_wr = reg_wr && reg_addr == 7'h0c;
   wire        mask_wr = reg_wr && reg_addr == 7'h11;
   // Write data one and two cycles back, so fields can be sliced
   always_ff @(posedge clk) begin
      wd_q <= reg_wdata;
      wd_q2 <= wd_q;
   end
   a_reg_answer: assert property (reg_rd && reg_addr != 7'h00 |=> reg_rvalid_ff)
      else $error("register read not answered");
   a_buf_answer: assert property (reg_rd && reg_addr == 7'h00 |-> ##2 reg_rvalid_ff)
      else $error("buffer read not answered");
   a_tx_base: assert property (reg_wr && reg_addr == 7'h0e |=> tx_buffer_base_ff == wd_q)
      else $error("tx base not stored");
   a_rx_base: assert property (reg_wr && reg_addr == 7'h0f |=> rx_buffer_base_ff == wd_q)
      else $error("rx base not stored");
   // Amplifier outputs sit two flip-flops behind the write: register, then output stage
   a_gain_store: assert property (amp_wr && reg_wdata[7:5] inside {[1:6]} |-> ##2 rx_amp_gain_code_ff == wd_q2[7:5])
      else $error("gain code not applied");
   a_gain_range: assert property (rx_amp_gain_code_ff inside {[1:6]})
      else $error("unused gain code applied");
   a_hb_store: assert property (amp_wr |-> ##2 high_band_amp_current_ff == wd_q2[1:0])
      else $error("high band field not stored");
   a_boost_tie: assert property (high_band_boost_ff == (high_band_amp_current_ff == 2'b11))
      else $error("boost disagrees with field");
   a_irq_cause: assert property ($rose(irq_ff) |-> $past(irq_event) != 8'h00 || $past(irq_event, 2) != 8'h00
      || $past(mask_wr) || $past(mask_wr, 2))
      else $error("interrupt rose without cause");
   a_irq_clear: assert property (reg_wr && reg_addr == 7'h12 && reg_wdata == 8'hff && irq_event == 8'h00
      |=> !irq_ff)
      else $error("interrupt stayed after clear");
endmodule
bind mfr_regs mfr_regs_checker chk (.clk, .reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rvalid_ff,
   .irq_event, .rx_amp_gain_code_ff, .high_band_amp_current_ff, .high_band_boost_ff, .tx_buffer_base_ff,
   .rx_buffer_base_ff, .irq_ff);
`default_nettype wire

//--- test/test_modem_fifo_pointer_irq_mask_regs.sv
// Bench for the register bank: host model on the strobes, modem side driven here.
// Assumes 40 MHz clock and inputs changed on the falling edge.
`timescale 1ns/100ps
`default_nettype none
module test_modem_fifo_pointer_irq_mask_regs;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] irq_event = 8'h00, pkt_start_addr = 8'h00, modem_buf_addr = 8'h00, modem_buf_wdata = 8'h00;
   logic pkt_start_load = 1'b0, modem_buf_wr = 1'b0;
   logic reg_wr, reg_rd, reg_rvalid_ff, high_band_boost_ff, irq_ff;
   logic [6:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata_ff, tx_buffer_base_ff, rx_buffer_base_ff, buf_rdata_ff;
   logic [2:0] rx_amp_gain_code_ff;
   logic [1:0] low_band_amp_current_ff, high_band_amp_current_ff;
   int errors = 0, check_count = 0;
   always #12.5 clk = ~clk;
   mfr_host_model host (.clk, .reg_rdata_ff, .reg_rvalid_ff, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
   mfr_regs uut (.clk, .reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_ff, .reg_rvalid_ff,
      .irq_event, .pkt_start_load, .pkt_start_addr, .modem_buf_wr, .modem_buf_addr, .modem_buf_wdata,
      .rx_amp_gain_code_ff, .low_band_amp_current_ff, .high_band_amp_current_ff, .high_band_boost_ff,
      .tx_buffer_base_ff, .rx_buffer_base_ff, .buf_rdata_ff, .irq_ff);
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Reset values through the host reads
   task automatic t_reset();
      logic [7:0] d;
      logic [6:0] ofs[6] = '{7'h0c, 7'h0d, 7'h0e, 7'h0f, 7'h11, 7'h12};
      logic [7:0] exp[6] = '{8'h20, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 6; i++) begin
         host.rd(ofs[i], d);
         check("reset_value", d, exp[i]);
      end
      $display("t_reset done");
   endtask
   // Every gain code, boost on, reserved bit set; low band kept at 00
   task automatic t_amp();
      logic [7:0] d;
      for (int c = 0; c < 8; c++) begin
         host.wr(7'h0c, {c[2:0], 5'h07});
         host.rd(7'h0c, d);
         check("amp_readback", d, {c[2:0], 5'h07});
         check("gain", {5'h00, rx_amp_gain_code_ff}, (c == 0 || c == 7) ? 8'h01 : {5'h00, c[2:0]});
         check("boost", {7'h00, high_band_boost_ff}, 8'h01);
         check("hb_current", {6'h00, high_band_amp_current_ff}, 8'h03);
         check("lb_current", {6'h00, low_band_amp_current_ff}, 8'h00);
      end
      host.wr(7'h0c, 8'h20);
      @(negedge clk);
      check("boost_off", {7'h00, high_band_boost_ff}, 8'h00);
      $display("t_amp done");
   endtask
   // Base registers at boundaries; start address is read-only; unmapped reads zero
   task automatic t_ptr();
      logic [7:0] d;
      host.wr(7'h0e, 8'hff);
      host.wr(7'h0f, 8'h01);
      host.rd(7'h0e, d);
      check("tx_base", d, 8'hff);
      host.rd(7'h0f, d);
      check("rx_base", d, 8'h01);
      @(negedge clk);
      pkt_start_load = 1'b1;
      pkt_start_addr = 8'h5a;
      @(negedge clk);
      pkt_start_load = 1'b0;
      pkt_start_addr = 8'ha5;
      host.wr(7'h10, 8'h00);
      host.rd(7'h10, d);
      check("last_start", d, 8'h5a);
      host.rd(7'h13, d);
      check("unmapped", d, 8'h00);
      $display("t_ptr done");
   endtask
   // Modem fills the top byte; host reads it through the pointer, which wraps
   task automatic t_buf();
      logic [7:0] d;
      @(negedge clk);
      modem_buf_wr = 1'b1;
      modem_buf_addr = 8'hff;
      modem_buf_wdata = 8'h3c;
      @(negedge clk);
      modem_buf_wr = 1'b0;
      modem_buf_wdata = 8'hc3;
      host.wr(7'h0d, 8'hff);
      repeat (2) @(negedge clk);
      check("buf_at_ptr", buf_rdata_ff, 8'h3c);
      host.rd(7'h00, d);
      check("buf_read", d, 8'h3c);
      host.rd(7'h0d, d);
      check("ptr_wrap", d, 8'h00);
      $display("t_buf done");
   endtask
   task automatic pulse(input logic [7:0] b);
      @(negedge clk);
      irq_event = b;
      @(negedge clk);
      irq_event = 8'h00;
      @(negedge clk);
   endtask
   // Each event masked, then unmasked with all other masks set
   task automatic t_irq();
      logic [7:0] d, b;
      for (int i = 0; i < 8; i++) begin
         b = 8'h01 << i;
         host.wr(7'h11, b);
         pulse(b);
         check("irq_masked", {7'h00, irq_ff}, 8'h00);
         host.rd(7'h12, d);
         check("flag_set", d, b);
         host.wr(7'h12, 8'hff);
         host.wr(7'h11, ~b);
         pulse(b);
         check("irq_on", {7'h00, irq_ff}, 8'h01);
         host.wr(7'h12, 8'hff);
         check("irq_cleared", {7'h00, irq_ff}, 8'h00);
      end
      $display("t_irq done");
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Run is about two hundred cycles; the watchdog allows about a hundred times that
   initial begin
      #500000;
      errors++;
      final_report();
   end
   initial begin
      repeat (12) @(negedge clk);
      reset = 1'b0;
      t_reset();
      t_amp();
      t_ptr();
      t_buf();
      t_irq();
      final_report();
   end
endmodule
`default_nettype wire

//--- verilog/mfr_buffer_ram.v
// Packet data buffer: single write port, registered read port.
// Assumes addresses and write strobe come from logic on clk.
`timescale 1ns/100ps
`default_nettype none
module mfr_buffer_ram #(
   parameter ADDR_W = 8,
   parameter DATA_W = 8
) (
   input  wire              clk,    // System clock
   input  wire              wr_en,  // Write strobe
   input  wire [ADDR_W-1:0] wr_addr, // Write address
   input  wire [DATA_W-1:0] wr_data, // Write data
   input  wire [ADDR_W-1:0] rd_addr, // Read address
   output reg  [DATA_W-1:0] rd_data  // Registered read data
);
   reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   // Memory has no reset, content is undefined at power up
   always @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule
`default_nettype wire

//--- verilog/mfr_consts.vh
// Register map constants for the modem buffer pointer and interrupt mask bank.
// Included by the register bank only; definitions only.
`ifndef MFR_CONSTS_VH
`define MFR_CONSTS_VH

// Register offsets
`define MFR_OFS_RX_AMP_CONFIG      7'h0c
`define MFR_OFS_BUF_ACCESS_PTR     7'h0d
`define MFR_OFS_TX_BUF_BASE        7'h0e
`define MFR_OFS_RX_BUF_BASE        7'h0f
`define MFR_OFS_LAST_PKT_START     7'h10
`define MFR_OFS_IRQ_MASK           7'h11
`define MFR_OFS_IRQ_FLAGS          7'h12
`define MFR_OFS_BUF_DATA           7'h00

// Amplifier field positions
`define MFR_GAIN_MSB               7
`define MFR_GAIN_LSB               5
`define MFR_LB_CUR_MSB             4
`define MFR_LB_CUR_LSB             3
`define MFR_RSVD_BIT               2
`define MFR_HB_CUR_MSB             1
`define MFR_HB_CUR_LSB             0

// Gain codes and high-band boost current code
`define MFR_GAIN_MAX               3'h1
`define MFR_GAIN_MIN               3'h6
`define MFR_HB_CUR_BOOST           2'h3

// Reset values
`define MFR_RST_RX_AMP_CONFIG      8'h20
`define MFR_RST_BUF_ACCESS_PTR     8'h00
`define MFR_RST_TX_BUF_BASE        8'h80
`define MFR_RST_RX_BUF_BASE        8'h00
`define MFR_RST_IRQ_MASK           8'h00
`define MFR_RST_IRQ_FLAGS          8'h00

`endif

//--- verilog/mfr_regs.v
// Modem register bank slice: amplifier config, buffer pointers, interrupt mask and flags.
// Assumes the serial host access is decoded into one-cycle read/write strobes on clk,
// and that modem events arrive as one-cycle pulses from logic on clk.
`timescale 1ns/100ps
`default_nettype none
`include "mfr_consts.vh"
module mfr_regs #(
   parameter ADDR_W = 7,
   parameter DATA_W = 8,
   parameter BUF_AW = 8
) (
   input  wire              clk,              // 40 MHz system clock
   input  wire              reset,            // Synchronous reset, active high
   input  wire              reg_wr,           // Host register write strobe
   input  wire              reg_rd,           // Host register read strobe
   input  wire [ADDR_W-1:0] reg_addr,         // Host register address
   input  wire [DATA_W-1:0] reg_wdata,        // Host write data
   output reg  [DATA_W-1:0] reg_rdata_ff,     // Host read data
   output reg               reg_rvalid_ff,    // Read data valid pulse
   input  wire [7:0]        irq_event,        // Modem event pulses, flag bit order
   input  wire              pkt_start_load,   // Modem latches last packet start
   input  wire [7:0]        pkt_start_addr,   // Start address of received packet
   input  wire              modem_buf_wr,     // Modem writes receive data to buffer
   input  wire [BUF_AW-1:0] modem_buf_addr,   // Modem buffer address
   input  wire [7:0]        modem_buf_wdata,  // Modem buffer data
   output reg  [2:0]        rx_amp_gain_code_ff,      // Effective gain step code
   output reg  [1:0]        low_band_amp_current_ff,  // Low-band amplifier current
   output reg  [1:0]        high_band_amp_current_ff, // High-band amplifier current
   output reg               high_band_boost_ff,       // High-band 150 percent boost on
   output reg  [7:0]        tx_buffer_base_ff,        // Transmit payload base
   output reg  [7:0]        rx_buffer_base_ff,        // Receive data base
   output reg  [7:0]        buf_rdata_ff,             // Buffer data read by modem
   output reg               irq_ff                    // Interrupt indication, active high
);
   // Register state
   reg [7:0] rx_amp_config_ff;
   reg [7:0] buffer_access_pointer_ff;
   reg [7:0] last_packet_start_ff;
   reg [7:0] interrupt_mask_ff;
   reg [7:0] interrupt_flag_register_ff;
   reg       buf_rd_pend_ff;
   reg [7:0] nxt_rdata;
   reg [7:0] nxt_flags;
   reg [2:0] nxt_gain;

   wire [7:0] ram_rdata;
   wire       host_buf_wr;
   wire       host_buf_rd;
   wire [BUF_AW-1:0] ram_wr_addr;
   wire [7:0]        ram_wr_data;
   wire              ram_wr;

   // Address compare used by several decoders
   function hit;
      input [ADDR_W-1:0] addr;
      input [ADDR_W-1:0] ofs;
      begin
         hit = (addr == ofs);
      end
   endfunction

   assign host_buf_wr = reg_wr && hit(reg_addr, `MFR_OFS_BUF_DATA);
   assign host_buf_rd = reg_rd && hit(reg_addr, `MFR_OFS_BUF_DATA);

   // Host write wins the port; modem write is dropped if both collide
   assign ram_wr      = host_buf_wr | modem_buf_wr;
   assign ram_wr_addr = host_buf_wr ? buffer_access_pointer_ff[BUF_AW-1:0] : modem_buf_addr;
   assign ram_wr_data = host_buf_wr ? reg_wdata : modem_buf_wdata;

   mfr_buffer_ram #(
      .ADDR_W (BUF_AW),
      .DATA_W (8)
   ) u_ram (
      .clk     (clk),
      .wr_en   (ram_wr),
      .wr_addr (ram_wr_addr),
      .wr_data (ram_wr_data),
      .rd_addr (buffer_access_pointer_ff[BUF_AW-1:0]),
      .rd_data (ram_rdata)
   );

   // Configuration registers, written by the host
   always @(posedge clk) begin
      if (reset) begin
         rx_amp_config_ff         <= `MFR_RST_RX_AMP_CONFIG;
         buffer_access_pointer_ff <= `MFR_RST_BUF_ACCESS_PTR;
         tx_buffer_base_ff        <= `MFR_RST_TX_BUF_BASE;
         rx_buffer_base_ff        <= `MFR_RST_RX_BUF_BASE;
         interrupt_mask_ff        <= `MFR_RST_IRQ_MASK;
      end else if (reg_wr) begin
         if (hit(reg_addr, `MFR_OFS_RX_AMP_CONFIG)) begin
            rx_amp_config_ff <= reg_wdata;
         end else if (hit(reg_addr, `MFR_OFS_BUF_ACCESS_PTR)) begin
            buffer_access_pointer_ff <= reg_wdata;
         end else if (hit(reg_addr, `MFR_OFS_TX_BUF_BASE)) begin
            tx_buffer_base_ff <= reg_wdata;
         end else if (hit(reg_addr, `MFR_OFS_RX_BUF_BASE)) begin
            rx_buffer_base_ff <= reg_wdata;
         end else if (hit(reg_addr, `MFR_OFS_IRQ_MASK)) begin
            interrupt_mask_ff <= reg_wdata;
         end else if (hit(reg_addr, `MFR_OFS_BUF_DATA)) begin
            buffer_access_pointer_ff <= buffer_access_pointer_ff + 8'h01;
         end
      end else if (host_buf_rd) begin
         buffer_access_pointer_ff <= buffer_access_pointer_ff + 8'h01;
      end
   end

   // latched from the modem, no reset on purpose
   always @(posedge clk) begin
      if (pkt_start_load) begin
         last_packet_start_ff <= pkt_start_addr;
      end
   end

   always @* begin
      nxt_flags = interrupt_flag_register_ff;
      if (reg_wr && hit(reg_addr, `MFR_OFS_IRQ_FLAGS)) begin
         nxt_flags = nxt_flags & ~reg_wdata;
      end
      // events set flags regardless of mask
      nxt_flags = nxt_flags | irq_event;
   end

   always @(posedge clk) begin
      if (reset) begin
         interrupt_flag_register_ff <= `MFR_RST_IRQ_FLAGS;
      end else begin
         interrupt_flag_register_ff <= interrupt_flag_register_ff == nxt_flags ?
                                       interrupt_flag_register_ff : nxt_flags;
      end
   end

   // each mask bit gates its own flag
   // masked flag never raises the output
   always @(posedge clk) begin
      if (reset) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(nxt_flags & ~interrupt_mask_ff);
      end
   end

   // only codes 1..6 are real steps; unused codes fall back to max gain
   always @* begin
      nxt_gain = rx_amp_config_ff[`MFR_GAIN_MSB:`MFR_GAIN_LSB];
      if (nxt_gain < `MFR_GAIN_MAX || nxt_gain > `MFR_GAIN_MIN) begin
         nxt_gain = `MFR_GAIN_MAX;
      end
   end

   // Amplifier controls out of flip-flops
   always @(posedge clk) begin
      if (reset) begin
         rx_amp_gain_code_ff      <= `MFR_GAIN_MAX;
         low_band_amp_current_ff  <= 2'h0;
         high_band_amp_current_ff <= 2'h0;
         high_band_boost_ff       <= 1'b0;
      end else begin
         rx_amp_gain_code_ff <= nxt_gain;
         // host keeps this at zero; passed on as written
         low_band_amp_current_ff  <= rx_amp_config_ff[`MFR_LB_CUR_MSB:`MFR_LB_CUR_LSB];
         high_band_amp_current_ff <= rx_amp_config_ff[`MFR_HB_CUR_MSB:`MFR_HB_CUR_LSB];
         high_band_boost_ff <= (rx_amp_config_ff[`MFR_HB_CUR_MSB:`MFR_HB_CUR_LSB] == `MFR_HB_CUR_BOOST);
      end
   end

   // Modem side sees buffer content at the pointer, two cycles after the pointer changes
   always @(posedge clk) begin
      if (reset) begin
         buf_rdata_ff <= 8'h00;
      end else begin
         buf_rdata_ff <= ram_rdata;
      end
   end

   // Read mux; unmapped offsets read zero
   always @* begin
      nxt_rdata = 8'h00;
      if (hit(reg_addr, `MFR_OFS_RX_AMP_CONFIG)) begin
         nxt_rdata = rx_amp_config_ff;
      end else if (hit(reg_addr, `MFR_OFS_BUF_ACCESS_PTR)) begin
         nxt_rdata = buffer_access_pointer_ff;
      end else if (hit(reg_addr, `MFR_OFS_TX_BUF_BASE)) begin
         nxt_rdata = tx_buffer_base_ff;
      end else if (hit(reg_addr, `MFR_OFS_RX_BUF_BASE)) begin
         nxt_rdata = rx_buffer_base_ff;
      end else if (hit(reg_addr, `MFR_OFS_LAST_PKT_START)) begin
         nxt_rdata = last_packet_start_ff;
      end else if (hit(reg_addr, `MFR_OFS_IRQ_MASK)) begin
         nxt_rdata = interrupt_mask_ff;
      end else if (hit(reg_addr, `MFR_OFS_IRQ_FLAGS)) begin
         nxt_rdata = interrupt_flag_register_ff;
      end
   end

   // Register reads answer next cycle; buffer reads wait one more for the RAM
   always @(posedge clk) begin
      if (reset) begin
         reg_rdata_ff   <= 8'h00;
         reg_rvalid_ff  <= 1'b0;
         buf_rd_pend_ff <= 1'b0;
      end else begin
         buf_rd_pend_ff <= host_buf_rd;
         reg_rvalid_ff  <= (reg_rd && !host_buf_rd) || buf_rd_pend_ff;
         if (buf_rd_pend_ff) begin
            reg_rdata_ff <= ram_rdata;
         end else if (reg_rd && !host_buf_rd) begin
            reg_rdata_ff <= nxt_rdata;
         end
      end
   end
endmodule
`default_nettype wire
